// >>> audio_out_ctrl.sv
// Audio output path control: short-circuit protection, driver and DAC pop
// reduction, digital sidetone mixer, analog mixer volume stepping, keyclick.
// Assumes one 125 MHz clock; short_detect_pin and osc_clk_pin are asynchronous.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "audio_out_cfg.svh"
module audio_out_ctrl #(
  parameter int unsigned CAP_SHORT_CYC  = `CAP_SHORT_MS * `CLK_KHZ,
  parameter int unsigned CAP_LONG_CYC   = `CAP_LONG_MS * `CLK_KHZ,
  parameter int unsigned VG_SHORT_CYC   = `VG_SHORT_MS * `CLK_KHZ,
  parameter int unsigned VG_LONG_CYC    = `VG_LONG_MS * `CLK_KHZ,
  parameter int unsigned DACPOP_CYC     = `DACPOP_BASE_US * `CLK_KHZ / 1000,
  parameter int unsigned KC_HALF_CYC    = `CLK_KHZ * 1000 / `KC_BASE_HZ_X2,
  parameter int unsigned STEP_CYC       = `STEP_US * `CLK_KHZ / 1000
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic [5:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [15:0]                reg_rdata,
  input  wire logic                  short_detect_pin,
  input  wire logic                  osc_clk_pin,
  input  wire audio_out_pkg::sample_t adc_sample,
  input  wire logic                  adc_sample_valid,
  input  wire audio_out_pkg::sample_t dac_in_l,
  input  wire audio_out_pkg::sample_t dac_in_r,
  input  wire logic                  dac_in_valid,
  output audio_out_pkg::sample_t     dac_mix_l,
  output audio_out_pkg::sample_t     dac_mix_r,
  output logic                       dac_mix_valid,
  output logic                       driver_enable,
  output logic                       driver_ready,
  output logic                       driver_current_limit,
  output logic                       dac_dc_ramp,
  output logic [1:0]                 dac_swing,
  output logic                       mixer_path_enable,
  output logic [6:0]                 mixer_gain,
  output audio_out_pkg::sample_t     keyclick_wave
);
  import audio_out_pkg::*;

  initial begin
    if (STEP_CYC < 1 || DACPOP_CYC < 1 || KC_HALF_CYC < 128 || VG_SHORT_CYC < 1)
      $error("audio_out_ctrl timing parameter too small");
  end

  // ==========================================================================
  // Helpers
  function automatic sc_mode_t decode_mode(input logic off_bit, input logic auto_bit);
    if (off_bit) return SC_OFF;
    else if (auto_bit) return SC_AUTO;
    else return SC_LIMIT;
  endfunction

  // 1.5 dB steps: four mantissas per 6 dB octave, then an arithmetic shift
  function automatic sample_t attenuate(input sample_t x, input logic [5:0] g);
    logic signed [25:0] prod;
    logic signed [9:0]  mant;
    prod = '0;
    case (g[1:0])
      2'h0: mant = 10'sh100;
      2'h1: mant = 10'sh0d7;
      2'h2: mant = 10'sh0b5;
      default: mant = 10'sh099;
    endcase
    prod = (x * mant) >>> (8 + int'(g[5:2]));
    return sample_t'(prod);
  endfunction

  function automatic sample_t sat_add(input sample_t a, input sample_t b);
    logic signed [16:0] s;
    s = 17'(a) + 17'(b);
    if (s > 17'sh07fff) return 16'sh7fff;
    else if (s < -17'sh08000) return -16'sh8000;
    else return s[15:0];
  endfunction

  // ==========================================================================
  // Registers
  logic [7:0]  st_reg;
  logic [15:0] pw_reg;
  logic [1:0]  swing;
  logic [1:0]  sc_bits;
  logic [3:0]  dacpop_reg;
  logic [1:0]  pop_reg;
  logic [6:0]  mix_target;
  logic [2:0]  kc_amp;
  logic [2:0]  kc_freq;
  logic [3:0]  kc_len;
  logic        kc_en;
  logic        sc_flag;
  logic        kc_start;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg     <= '0;
      pw_reg     <= `REG_RESET;
      swing      <= '0;
      sc_bits    <= '0;
      dacpop_reg <= '0;
      pop_reg    <= '0;
      mix_target <= `MIX_MUTE;
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_SIDETONE: st_reg <= reg_wdata[7:0];
        `REG_POWER:    pw_reg <= reg_wdata;
        `REG_CTRL3:    swing <= reg_wdata[`SWING_HI:`SWING_LO];
        `REG_PROTECT: begin
          sc_bits    <= reg_wdata[`SC_OFF_BIT:`SC_AUTO_BIT];
          dacpop_reg <= reg_wdata[`DACPOP_EN_BIT:`DACPOP_LO];
        end
        `REG_POP:      pop_reg <= reg_wdata[`POP_DIS_BIT:`POP_SEL_BIT];
        `REG_MIXVOL:   mix_target <= reg_wdata[`MIX_HI:`MIX_LO];
        default: ;
      endcase
    end
  end

  // Any write to the keyclick register restarts the burst
  assign kc_start = reg_wr && (reg_addr == `REG_KEYCLICK);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      kc_amp  <= '0;
      kc_freq <= '0;
      kc_len  <= '0;
    end else if (reg_wr && reg_addr == `REG_KEYCLICK) begin
      kc_amp  <= reg_wdata[`KC_AMP_HI:`KC_AMP_LO];
      kc_freq <= reg_wdata[`KC_FREQ_HI:`KC_FREQ_LO];
      kc_len  <= reg_wdata[`KC_LEN_HI:`KC_LEN_LO];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_SIDETONE: reg_rdata <= {8'h00, st_reg};
        `REG_KEYCLICK: reg_rdata <= {kc_en, kc_amp, 1'b0, kc_freq, kc_len, 4'h0};
        `REG_POWER:    reg_rdata <= pw_reg;
        `REG_CTRL3:    reg_rdata <= {5'h00, swing, 9'h000};
        `REG_PROTECT:  reg_rdata <= {7'h00, sc_bits, sc_flag, dacpop_reg, 2'h0};
        `REG_POP:      reg_rdata <= {13'h0000, pop_reg, 1'b0};
        `REG_MIXVOL:   reg_rdata <= {9'h000, mix_target};
        default:       reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  assign dac_swing = swing;

  logic dac_pw;
  logic adc_pw;
  logic mix_act;
  sc_mode_t mode;
  assign dac_pw  = pw_reg[`PW_DAC_BIT];
  assign adc_pw  = pw_reg[`PW_ADC_BIT];
  assign mix_act = pw_reg[`PW_MIX_BIT] && pw_reg[`PW_SE_BIT];
  assign mode    = decode_mode(sc_bits[1], sc_bits[0]);

  // ==========================================================================
  // Pin synchronisers
  logic sc_s1, sc_s2, osc_s1, osc_s2, osc_s3;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {sc_s1, sc_s2, osc_s1, osc_s2, osc_s3} <= '0;
    end else begin
      sc_s1  <= short_detect_pin;
      sc_s2  <= sc_s1;
      osc_s1 <= osc_clk_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // ==========================================================================
  // Short-circuit protection
  logic shutdown;
  logic routes_on;
  assign routes_on = dac_pw || mix_act || kc_en;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sc_flag              <= 1'b0;
      shutdown             <= 1'b0;
      driver_current_limit <= 1'b0;
    end else begin
      driver_current_limit <= (mode == SC_LIMIT);
      case (mode)
        SC_LIMIT: begin
          sc_flag  <= sc_s2;
          shutdown <= 1'b0;
        end
        SC_AUTO: begin
          if (sc_s2) begin
            sc_flag  <= 1'b1;
            shutdown <= 1'b1;
          end else if (!routes_on) begin
            sc_flag  <= 1'b0;
            shutdown <= 1'b0;
          end
        end
        default: begin
          sc_flag  <= 1'b0;
          shutdown <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Output drivers and their pop ramp
  drv_state_t  drv_state;
  logic        drv_allowed;
  logic        drv_start;
  logic        drv_busy;
  logic        drv_done;
  logic [31:0] drv_load;
  assign drv_allowed = routes_on && !shutdown;
  assign drv_start   = (drv_state == DRV_OFF) && drv_allowed && !pop_reg[1];
  always_comb begin
    if (pw_reg[`PW_VIRTUAL_GROUND_AMP_BIT])
      drv_load = pop_reg[0] ? VG_LONG_CYC : VG_SHORT_CYC;
    else
      drv_load = pop_reg[0] ? CAP_LONG_CYC : CAP_SHORT_CYC;
  end

  ramp_timer #(.WIDTH(32)) u_drv_ramp (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (drv_start),
    .load     (drv_load),
    .busy     (drv_busy),
    .done     (drv_done)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      drv_state     <= DRV_OFF;
      driver_enable <= 1'b0;
      driver_ready  <= 1'b0;
    end else begin
      driver_enable <= drv_allowed;
      case (drv_state)
        DRV_OFF: begin
          if (drv_allowed) drv_state <= pop_reg[1] ? DRV_ON : DRV_RAMP;
        end
        DRV_RAMP: begin
          if (!drv_allowed) drv_state <= DRV_OFF;
          else if (drv_done) drv_state <= DRV_ON;
        end
        DRV_ON: if (!drv_allowed) drv_state <= DRV_OFF;
        default: drv_state <= DRV_OFF;
      endcase
      driver_ready <= (drv_state == DRV_ON) && drv_allowed;
    end
  end

  // ==========================================================================
  // DAC level ramp on DAC power change
  logic        dac_pw_q;
  logic        dpop_start;
  logic [31:0] dpop_load;
  logic        dpop_busy;
  assign dpop_start = (dac_pw != dac_pw_q) && dacpop_reg[3];
  assign dpop_load  = DACPOP_CYC << dacpop_reg[2:0];

  ramp_timer #(.WIDTH(32)) u_dac_ramp (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (dpop_start),
    .load     (dpop_load),
    .busy     (dpop_busy),
    .done     ()
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_pw_q    <= 1'b0;
      dac_dc_ramp <= 1'b0;
    end else begin
      dac_pw_q    <= dac_pw;
      dac_dc_ramp <= dpop_busy || dpop_start;
    end
  end

  // ==========================================================================
  // Digital sidetone
  logic       st_on;
  logic [5:0] st_pending;
  logic [5:0] st_gain;
  logic       st_sign;
  sample_t    st_sample;
  assign st_on = !st_reg[`ST_DIS_BIT] && dac_pw
                 && (pw_reg[`ADC_RATE_HI:`ADC_RATE_LO] == pw_reg[`DAC_RATE_HI:`DAC_RATE_LO]);
  // Gains past -48 dB clamp to the last step
  assign st_pending = (st_reg[5:0] > `ST_GAIN_MAX) ? `ST_GAIN_MAX : st_reg[5:0];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_gain   <= '0;
      st_sign   <= 1'b0;
      st_sample <= '0;
    end else if (adc_sample_valid) begin
      st_sign <= adc_sample[15];
      // Switching on a sign change or zero keeps the step inaudible
      if (adc_sample[15] != st_sign || adc_sample == '0) st_gain <= st_pending;
      st_sample <= attenuate(adc_sample, st_gain);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_mix_l     <= '0;
      dac_mix_r     <= '0;
      dac_mix_valid <= 1'b0;
    end else begin
      dac_mix_valid <= dac_in_valid;
      if (dac_in_valid) begin
        dac_mix_l <= st_on ? sat_add(dac_in_l, st_sample) : dac_in_l;
        dac_mix_r <= st_on ? sat_add(dac_in_r, st_sample) : dac_in_r;
      end
    end
  end

  // ==========================================================================
  // Analog mixer volume soft-stepping
  logic [31:0] step_cnt;
  logic        step_tick;
  logic        conv_on;
  logic [6:0]  mix_goal;
  assign conv_on  = adc_pw || dac_pw;
  assign mix_goal = (mix_target > `MIX_MIN_CODE) ? `MIX_MUTE : mix_target;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt  <= '0;
      step_tick <= 1'b0;
    end else if (conv_on) begin
      step_tick <= (step_cnt == STEP_CYC - 1);
      step_cnt  <= (step_cnt == STEP_CYC - 1) ? '0 : step_cnt + 32'h1;
    end else begin
      step_tick <= osc_s2 && !osc_s3;
      step_cnt  <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mixer_gain        <= `MIX_MUTE;
      mixer_path_enable <= 1'b0;
    end else begin
      mixer_path_enable <= mix_act;
      // Mute is reached by stepping through the quietest code first
      if (step_tick && mixer_gain != mix_goal) begin
        if (mixer_gain == `MIX_MUTE) mixer_gain <= `MIX_MIN_CODE;
        else if (mix_goal == `MIX_MUTE && mixer_gain == `MIX_MIN_CODE) mixer_gain <= `MIX_MUTE;
        else if (mixer_gain < mix_goal) mixer_gain <= mixer_gain + 7'h1;
        else mixer_gain <= mixer_gain - 7'h1;
      end
    end
  end

  // ==========================================================================
  // Keyclick generator, independent of converter power
  logic [31:0] kc_cnt;
  logic [6:0]  kc_halves;
  logic        kc_phase;
  sample_t     kc_level;
  assign kc_level = sample_t'((16'(kc_amp) + 16'h0001) << `KC_AMP_SHIFT);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      kc_en         <= 1'b0;
      kc_cnt        <= '0;
      kc_halves     <= '0;
      kc_phase      <= 1'b0;
      keyclick_wave <= '0;
    end else begin
      if (kc_start) begin
        kc_en     <= 1'b1;
        kc_cnt    <= (KC_HALF_CYC >> reg_wdata[`KC_FREQ_HI:`KC_FREQ_LO]) - 1;
        kc_halves <= {1'b0, reg_wdata[`KC_LEN_HI:`KC_LEN_LO], 2'b11} + 7'h1;
        kc_phase  <= 1'b1;
      end else if (kc_en) begin
        if (kc_cnt == '0) begin
          kc_cnt    <= (KC_HALF_CYC >> kc_freq) - 1;
          kc_phase  <= !kc_phase;
          kc_halves <= kc_halves - 7'h1;
          if (kc_halves == 7'h1) kc_en <= 1'b0;
        end else begin
          kc_cnt <= kc_cnt - 32'h1;
        end
      end
      keyclick_wave <= !kc_en ? '0 : (kc_phase ? kc_level : -kc_level);
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_limit_flag: assert property (mode == SC_LIMIT && $past(mode) == SC_LIMIT |-> sc_flag == $past(sc_s2))
    else $error("limit flag does not follow short");
  a_off_no_flag: assert property (mode == SC_OFF |=> !sc_flag)
    else $error("flag set with protection off");
  a_auto_cut: assert property (mode == SC_AUTO && sc_s2 ##1 mode == SC_AUTO |=> !driver_enable)
    else $error("drivers not cut on short");
  a_auto_hold: assert property (mode == SC_AUTO && sc_flag && routes_on && !sc_s2 |=> sc_flag)
    else $error("auto flag cleared with route on");
  a_ramp_delay: assert property (drv_start |=> !driver_ready [*2])
    else $error("driver ready without ramp");
  a_ramp_skip: assert property ($rose(drv_allowed) && pop_reg[1] |-> ##[2:3] driver_ready)
    else $error("driver ready late with ramp off");
  a_sidetone_off: assert property (dac_in_valid && !st_on |=> dac_mix_l == $past(dac_in_l))
    else $error("sidetone mixed while disabled");
  a_kc_clear: assert property ($fell(kc_en) |-> $past(kc_halves) == 7'h1 && $past(kc_cnt) == '0)
    else $error("keyclick ended early");
  a_mix_step: assert property (!step_tick |=> $stable(mixer_gain))
    else $error("mixer gain moved off a step tick");
  a_read_once: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");

  c_auto_short: cover property (mode == SC_AUTO && sc_s2 ##1 sc_flag);
  c_keyclick:   cover property ($fell(kc_en));
  c_ramp_done:  cover property (drv_done ##1 drv_state == DRV_ON);
  c_st_switch:  cover property (adc_sample_valid && st_gain != st_pending);
endmodule // audio_out_ctrl

// >>> audio_out_cfg.svh
// Constants of the audio output control block: register offsets, field positions,
// reset values and timing figures. Assumes a 125 MHz core clock.
`ifndef AUDIO_OUT_CFG_SVH
`define AUDIO_OUT_CFG_SVH
// ==========================================================================
// Register offsets
`define REG_SIDETONE   6'h03
`define REG_KEYCLICK   6'h04
`define REG_POWER      6'h05
`define REG_CTRL3      6'h06
`define REG_PROTECT    6'h1d
`define REG_POP        6'h1e
`define REG_MIXVOL     6'h1f
// ==========================================================================
// Field positions
`define SWING_HI       10
`define SWING_LO       9
`define SC_OFF_BIT     8
`define SC_AUTO_BIT    7
`define SC_FLAG_BIT    6
`define DACPOP_EN_BIT  5
`define DACPOP_HI      4
`define DACPOP_LO      2
`define POP_DIS_BIT    2
`define POP_SEL_BIT    1
`define ST_DIS_BIT     7
`define ST_GAIN_HI     5
`define ST_GAIN_LO     0
`define KC_EN_BIT      15
`define KC_AMP_HI      14
`define KC_AMP_LO      12
`define KC_FREQ_HI     10
`define KC_FREQ_LO     8
`define KC_LEN_HI      7
`define KC_LEN_LO      4
`define PW_DAC_BIT     0
`define PW_ADC_BIT     1
`define PW_MIX_BIT     2
`define PW_VIRTUAL_GROUND_AMP_BIT    3
`define PW_SE_BIT      4
`define ADC_RATE_HI    10
`define ADC_RATE_LO    8
`define DAC_RATE_HI    14
`define DAC_RATE_LO    12
`define MIX_HI         6
`define MIX_LO         0
// ==========================================================================
// Values and reset values
`define ST_GAIN_MAX    6'h20
`define MIX_MUTE       7'h7f
`define MIX_MIN_CODE   7'h5d
`define SWING_MAX      2'h3
`define DACPOP_BEST    3'h4
`define REG_RESET      16'h0000
`define KC_AMP_SHIFT   11
// ==========================================================================
// Timing
`define CLK_KHZ        125000
`define CAP_SHORT_MS   800
`define CAP_LONG_MS    4000
`define VG_SHORT_MS    1
`define VG_LONG_MS     5
`define STEP_US        20
`define DACPOP_BASE_US 1000
`define KC_BASE_HZ_X2  125
`endif

// >>> audio_out_pkg.sv
// Types shared by the audio output control block.
// Assumes audio_out_cfg.svh is compiled alongside.
package audio_out_pkg;
  typedef enum logic [1:0] {SC_LIMIT, SC_AUTO, SC_OFF} sc_mode_t;
  typedef enum logic [1:0] {DRV_OFF, DRV_RAMP, DRV_ON} drv_state_t;
  typedef logic signed [15:0] sample_t;
endpackage

// >>> ramp_timer.sv
// One-shot delay timer used for the driver and DAC pop ramps.
// Assumes start is a one-cycle pulse in the core clock domain.
`timescale 1ns/1ps
module ramp_timer #(
  parameter int WIDTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load,
  output logic                  busy,
  output logic                  done
);
  logic [WIDTH-1:0] count;

  initial begin
    if (WIDTH < 2 || WIDTH > 40) $error("ramp_timer WIDTH out of range");
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= (load == '0) ? WIDTH'(1) : load;
        busy  <= 1'b1;
      end else if (busy) begin
        if (count == WIDTH'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count - WIDTH'(1);
      end
    end
  end
endmodule // ramp_timer

// >>> audio_load_model.sv
// Behavioural headphone or speaker load on the output drivers.
// Assumes short_req comes from the bench; a short only draws current while powered.
`timescale 1ns/1ps
module audio_load_model (
  input  wire logic driver_enable,
  input  wire logic short_req,
  output logic      short_detect_pin
);
  // A shorted plug draws excess current only while the drivers are powered
  assign short_detect_pin = short_req & driver_enable;
endmodule // audio_load_model

// >>> audio_output_protect_mix_keyclick_bench.sv
// Self-checking bench for audio_out_ctrl with small timing parameters.
// Assumes audio_out_cfg.svh, audio_out_pkg and audio_load_model are compiled first.
`timescale 1ns/1ps
module audio_output_protect_mix_keyclick_bench;
  import audio_out_pkg::*;
  logic core_clk, reset_n, reg_wr, reg_rd, short_req, short_detect_pin, dac_in_valid;
  logic osc_clk_pin, adc_sample_valid, dac_dc_ramp, mixer_path_enable;
  logic [1:0]  dac_swing;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic driver_enable, driver_ready, driver_current_limit, dac_mix_valid;
  logic [6:0]  mixer_gain;
  sample_t     dac_in_l, dac_in_r, dac_mix_l, dac_mix_r, keyclick_wave, adc_sample;
  int bad_count = 0;
  int num_checks = 0;
  logic [37:0] rows [4] = '{{6'h1d, 16'h0040, 16'h0000}, {6'h1d, 16'h0030, 16'h0030},
                            {6'h1d, 16'h01b0, 16'h01b0}, {6'h3f, 16'hffff, 16'h0000}};
  logic [15:0] modes [3] = '{16'h0000, 16'h0080, 16'h0100};
  // Power word, sidetone sample, expected left mix of a 16'h1000 DAC sample
  logic [47:0] st_rows [4] = '{{16'h0001, 16'h0400, 16'h1400}, {16'h0001, 16'hfc00, 16'h0c00},
                               {16'h0001, 16'h0400, 16'h1200}, {16'h1001, 16'h0400, 16'h1000}};
  logic [2:0]  fl = 3'b011, de = 3'b101, cl = 3'b001;
  // ==========================================================================
  // Design and load
  audio_out_ctrl #(.CAP_SHORT_CYC(20), .DACPOP_CYC(4), .KC_HALF_CYC(256), .STEP_CYC(3))
    audio_out_ctrl_inst (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .short_detect_pin(short_detect_pin), .osc_clk_pin(osc_clk_pin), .adc_sample(adc_sample),
    .adc_sample_valid(adc_sample_valid), .dac_in_l(dac_in_l), .dac_in_r(dac_in_r),
    .dac_in_valid(dac_in_valid), .dac_mix_l(dac_mix_l), .dac_mix_r(dac_mix_r),
    .dac_mix_valid(dac_mix_valid), .driver_enable(driver_enable),
    .driver_ready(driver_ready), .driver_current_limit(driver_current_limit),
    .dac_dc_ramp(dac_dc_ramp), .dac_swing(dac_swing), .mixer_path_enable(mixer_path_enable),
    .mixer_gain(mixer_gain),
    .keyclick_wave(keyclick_wave));
  audio_load_model audio_load_model_inst (.driver_enable(driver_enable),
    .short_req(short_req), .short_detect_pin(short_detect_pin));
  // ==========================================================================
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_word(logic [15:0] got, logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Leaves the read data settled in reg_rdata for the caller
  task automatic rd(logic [5:0] a);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic cycles(int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One sidetone sample, then one DAC sample, then the left mix
  task automatic mix_row(logic [15:0] a, logic [15:0] exp);
    @(posedge core_clk);
    adc_sample <= a; adc_sample_valid <= 1'b1;
    @(posedge core_clk);
    adc_sample_valid <= 1'b0; dac_in_l <= 16'sh1000; dac_in_valid <= 1'b1;
    @(posedge core_clk);
    dac_in_valid <= 1'b0;
    #1;
    chk_word(dac_mix_l, exp);
  endtask
  // ==========================================================================
  // Stimulus
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    int n;
    reset_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    short_req = 1'b0; dac_in_valid = 1'b0; dac_in_l = '0; dac_in_r = '0;
    osc_clk_pin = 1'b0; adc_sample_valid = 1'b0; adc_sample = '0;
    cycles(16);
    chk_word({9'h000, mixer_gain}, 16'h007f);
    chk_bit(driver_enable, 1'b0);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][37:32], rows[i][31:16]);
      rd(rows[i][37:32]);
      chk_word(reg_rdata, rows[i][15:0]);
    end
    // Ramp on by default, short charge time: not ready early, ready in bounded time
    wr(6'h1d, 16'h0000);
    wr(6'h05, 16'h0001);
    cycles(10);
    chk_bit(driver_ready, 1'b0);
    n = 0;
    while (driver_ready !== 1'b1) begin
      if (++n > 60) begin
        $display("CHECK FAILED t=%0t driver never ready", $time);
        bad_count++;
        report_and_stop();
      end
      @(posedge core_clk);
    end
    chk_bit(driver_enable, 1'b1);
    // Sidetone disabled: mix passes the DAC input unchanged
    wr(6'h03, 16'h0080);
    @(posedge core_clk);
    dac_in_l <= 16'sh1234; dac_in_r <= 16'sh8001; dac_in_valid <= 1'b1;
    @(posedge core_clk);
    dac_in_valid <= 1'b0;
    #1;
    chk_word(dac_mix_l, 16'h1234);
    chk_word(dac_mix_r, 16'h8001);
    chk_bit(dac_mix_valid, 1'b1);
    // Sidetone on: a new gain waits for a sign change, then halves the sample
    wr(6'h03, 16'h0004);
    foreach (st_rows[i]) begin
      wr(6'h05, st_rows[i][47:32]);
      mix_row(st_rows[i][31:16], st_rows[i][15:0]);
    end
    wr(6'h06, 16'h0600);
    cycles(2);
    chk_word({14'h0000, dac_swing}, 16'h0003);
    // Each protection mode: short on, short off, then routes off
    foreach (modes[i]) begin
      wr(6'h1d, modes[i]);
      wr(6'h05, 16'h0001);
      short_req <= 1'b1;
      cycles(8);
      rd(6'h1d);
      chk_bit(reg_rdata[6], fl[i]);
      chk_bit(driver_enable, de[i]);
      chk_bit(driver_current_limit, cl[i]);
      short_req <= 1'b0;
      cycles(8);
      rd(6'h1d);
      chk_bit(reg_rdata[6], i == 1);
      wr(6'h05, 16'h0000);
      cycles(6);
      rd(6'h1d);
      chk_bit(reg_rdata[6], 1'b0);
    end
    // Keyclick with converters off: amp 2, freq 3 (32-cycle halves), 4 halves
    wr(6'h04, 16'ha300);
    cycles(2);
    #1;
    chk_word(keyclick_wave, 16'h1800);
    rd(6'h04);
    chk_bit(reg_rdata[15], 1'b1);
    cycles(140);
    #1;
    chk_word(keyclick_wave, 16'h0000);
    rd(6'h04);
    chk_bit(reg_rdata[15], 1'b0);
    // Driver ramp off: ready two cycles after the mixer route comes on
    wr(6'h1e, 16'h0004);
    wr(6'h05, 16'h0015);
    cycles(3);
    chk_bit(driver_ready, 1'b1);
    chk_bit(mixer_path_enable, 1'b1);
    // Converters on: counter steps through the quietest code to the target
    wr(6'h1f, 16'h005c);
    cycles(12);
    chk_word({9'h000, mixer_gain}, 16'h005c);
    // Converters off: only oscillator edges step the gain
    wr(6'h05, 16'h0014);
    wr(6'h1f, 16'h007f);
    cycles(12);
    chk_word({9'h000, mixer_gain}, 16'h005c);
    repeat (2) begin
      osc_clk_pin <= 1'b1;
      cycles(3);
      osc_clk_pin <= 1'b0;
      cycles(3);
    end
    chk_word({9'h000, mixer_gain}, 16'h007f);
    // DAC power-up with the level ramp enabled, length code 100
    wr(6'h1d, 16'h0030);
    wr(6'h05, 16'h0001);
    cycles(4);
    chk_bit(dac_dc_ramp, 1'b1);
    cycles(70);
    chk_bit(dac_dc_ramp, 1'b0);
    report_and_stop();
  end
endmodule // audio_output_protect_mix_keyclick_bench
